// file: src/vpi_cfg.svh
`ifndef VPI_CFG_SVH
`define VPI_CFG_SVH
// Sizes
`define VPI_NODES 64
`define VPI_SRC_W 6
`define VPI_LVL_W 4
`define VPI_STACK 16
`define VPI_SP_W 5
`define VPI_VTB_W 15
`define VPI_VTB_LSB 9
`define VPI_MEM_AW 24
`define VPI_WB_AW 10
// Register byte offsets
`define VPI_OFF_CTRL 10'h000
`define VPI_OFF_LEVELS 10'h004
`define VPI_OFF_ENC_LVL 10'h008
`define VPI_OFF_ENC_SRC 10'h00c
`define VPI_OFF_VTB 10'h010
`define VPI_OFF_NODE 10'h100
// Field positions
`define VPI_CTRL_GE 7
`define VPI_CTRL_TE 6
`define VPI_NODE_M 7
`define VPI_NODE_P 6
`define VPI_NODE_E 5
`define VPI_RUN_LSB 4
// Table addresses
`define VPI_EXIT_OFS 9'h100
`define VPI_ENTRY_OFS 9'h000
`endif

// file: src/vpi_pkg.sv
`include "vpi_cfg.svh"
package vpi_pkg;
  typedef logic [`VPI_NODES-1:0][`VPI_LVL_W-1:0] vpi_lvl_arr_t;
  typedef logic [`VPI_STACK-1:0][`VPI_LVL_W-1:0] vpi_stack_t;
  typedef struct packed {
    logic [`VPI_NODES-1:0] pend;
    logic [`VPI_NODES-1:0] en;
    vpi_lvl_arr_t prio;
    logic [`VPI_NODES-1:0] src_prev;
    vpi_stack_t stack;
    logic [`VPI_SP_W-1:0] sp;
    logic [`VPI_LVL_W-1:0] running;
    logic [`VPI_LVL_W-1:0] forced;
    logic ge;
    logic te;
    logic [`VPI_VTB_W-1:0] vector_table_base;
    logic req;
    logic wb_ack;
    logic [31:0] rdata;
  } vpi_state_t;
endpackage : vpi_pkg

// file: src/vpi_controller.sv
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vpi_cfg.svh"
// Operation
// - Forced level raises threshold, running untouched
// - Encoder level register shows winning priority
// - Encoder source register shows winning number
// - Table base keeps bits 23..9 only
// - Table word read drops processor request
// - Active comparator read acknowledges, clears, pushes
// - Word write at base+0x100 exits routine
// - Table enable off: plain memory access
// - Modify bit reads zero, gates pending write
// - Source activation sets pending; acknowledge clears
// - Disabled node never requests
// - Four-bit priority, zero never requests
// - Request needs pending, enable, nonzero priority
// - Standby off resets registers, blocks writes
// - Pending flags survive standby, always capture
// - Request needs global and table enable
// - Global disable keeps active request
// - Comparator raises request, held until table word read
// - Encoder reports source zero when idle
// - Exit pops interrupted priority from stack
module vpi_controller (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset, high
  input wire logic standby_controller_enable_i, // Standby enable, low resets
  input wire logic [`VPI_NODES-1:0] source_i, // Peripheral requests, same clock
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [`VPI_WB_AW-1:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Wishbone ack
  input wire logic mem_stb_i, // CPU memory access pulse
  input wire logic mem_we_i, // CPU access is write
  input wire logic mem_word_i, // CPU access is 32-bit
  input wire logic [`VPI_MEM_AW-1:0] mem_addr_i, // CPU byte address
  output logic [`VPI_MEM_AW-1:0] mem_addr_o, // Address sent to memory
  output logic cpu_request_n_o // Processor request, low active
);
  vpi_pkg::vpi_state_t s;
  vpi_pkg::vpi_state_t n;
  logic [`VPI_LVL_W-1:0] enc_lvl;
  logic [`VPI_SRC_W-1:0] enc_raw;
  logic [`VPI_SRC_W-1:0] enc_src;
  logic [`VPI_LVL_W-1:0] threshold;
  logic comp;
  logic tbl_rd;
  logic tbl_wr;
  logic ack_ev;
  logic exit_ev;
  logic [`VPI_NODES-1:0] rise;

  // Highest eligible node; ties go to the lowest number
  function automatic logic [`VPI_LVL_W+`VPI_SRC_W-1:0] enc_pick(
    input logic [`VPI_NODES-1:0] p,
    input logic [`VPI_NODES-1:0] e,
    input vpi_pkg::vpi_lvl_arr_t pr);
    logic [`VPI_LVL_W-1:0] bl;
    logic [`VPI_SRC_W-1:0] bs;
    bl = '0;
    bs = '0;
    for (int i = 0; i < `VPI_NODES; i++) begin
      if (p[i] && e[i] && pr[i] > bl) begin
        bl = pr[i];
        bs = i[`VPI_SRC_W-1:0];
      end
    end
    return {bl, bs};
  endfunction : enc_pick

  // Encoder and comparator
  assign {enc_lvl, enc_raw} = enc_pick(s.pend, s.en, s.prio);
  assign threshold = (s.forced > s.running) ? s.forced : s.running;
  assign comp = enc_lvl > threshold;
  assign enc_src = comp ? enc_raw : '0;

  // Table snoop; only word accesses count, so a debugger can dump with bytes
  assign tbl_rd = mem_stb_i && !mem_we_i && mem_word_i && s.te
    && mem_addr_i == {s.vector_table_base, `VPI_ENTRY_OFS};
  assign tbl_wr = mem_stb_i && mem_we_i && mem_word_i && s.te
    && mem_addr_i == {s.vector_table_base, `VPI_EXIT_OFS};
  assign ack_ev = tbl_rd && comp;
  assign exit_ev = tbl_wr;
  assign rise = source_i & ~s.src_prev;

  // Entry read redirected to the winner's slot, combinational on purpose
  always_comb begin
    mem_addr_o = mem_addr_i;
    if (tbl_rd) begin
      mem_addr_o = {s.vector_table_base, 1'b0, enc_src, 2'b00};
    end
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.wb_ack;
  assign cpu_request_n_o = ~s.req;

  // Next state
  always_comb begin
    logic acc;
    logic wr;
    logic [5:0] idx;
    logic [7:0] b0;
    n = s;
    acc = wb_cyc_i && wb_stb_i && !s.wb_ack;
    wr = acc && wb_we_i && standby_controller_enable_i;
    idx = wb_adr_i[7:2];
    b0 = wb_dat_i[7:0];
    n.wb_ack = acc;
    n.src_prev = source_i;
    // Register reads, unmapped reads return zero
    if (acc && !wb_we_i) begin
      n.rdata = '0;
      if (wb_adr_i[9:8] == 2'b01) begin
        n.rdata[`VPI_NODE_P] = s.pend[idx];
        n.rdata[`VPI_NODE_E] = s.en[idx];
        n.rdata[3:0] = s.prio[idx]; // Modify bit stays zero
      end else begin
        case (wb_adr_i)
          `VPI_OFF_CTRL: n.rdata[7:6] = {s.ge, s.te};
          `VPI_OFF_LEVELS: n.rdata[7:0] = {s.running, s.forced};
          `VPI_OFF_ENC_LVL: n.rdata[3:0] = enc_lvl;
          `VPI_OFF_ENC_SRC: n.rdata[5:0] = enc_src;
          `VPI_OFF_VTB: n.rdata[23:9] = s.vector_table_base;
          default: n.rdata = '0;
        endcase
      end
    end
    // Register writes; running level is hardware only
    if (wr && wb_adr_i[9:8] == 2'b01) begin
      if (wb_sel_i[0]) begin
        n.en[idx] = b0[`VPI_NODE_E];
        n.prio[idx] = b0[3:0];
        if (b0[`VPI_NODE_M]) begin
          n.pend[idx] = b0[`VPI_NODE_P];
        end
      end
    end else if (wr) begin
      case (wb_adr_i)
        `VPI_OFF_CTRL: begin
          if (wb_sel_i[0]) begin
            n.ge = b0[`VPI_CTRL_GE];
            n.te = b0[`VPI_CTRL_TE];
          end
        end
        `VPI_OFF_LEVELS: begin
          if (wb_sel_i[0]) begin
            n.forced = b0[3:0];
          end
        end
        `VPI_OFF_VTB: begin
          if (wb_sel_i[1]) begin
            n.vector_table_base[6:0] = wb_dat_i[15:9];
          end
          if (wb_sel_i[2]) begin
            n.vector_table_base[14:7] = wb_dat_i[23:16];
          end
        end
        default: n.ge = n.ge;
      endcase
    end
    // Acknowledge: push interrupted level, take the winner's
    if (ack_ev) begin
      n.pend[enc_src] = 1'b0;
      n.stack[s.sp[3:0]] = s.running;
      n.sp = s.sp + 5'h01;
      n.running = enc_lvl;
    end else if (exit_ev && s.sp != '0) begin
      n.running = s.stack[s.sp[3:0] - 4'h1];
      n.sp = s.sp - 5'h01;
    end
    // Request is cleared by the entry read here, and by standby off below
    if (tbl_rd) begin
      n.req = 1'b0;
    end else if (comp && s.ge && s.te) begin
      n.req = 1'b1;
    end
    // Hardware set beats any clear in the same cycle
    n.pend = n.pend | rise;
    // Standby off: everything but pending, source history and bus read/ack state back to reset
    if (!standby_controller_enable_i) begin
      n.en = '0;
      n.prio = '0;
      n.stack = '0;
      n.sp = '0;
      n.running = '0;
      n.forced = '0;
      n.ge = 1'b0;
      n.te = 1'b0;
      n.vector_table_base = '0;
      n.req = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Checks
  req_hold_a: assert property (s.req && !tbl_rd && standby_controller_enable_i
    |=> s.req) else $error("request dropped without acknowledge");
  req_drop_a: assert property (tbl_rd |=> !s.req)
    else $error("request not dropped by table read");
  ack_push_a: assert property (ack_ev && standby_controller_enable_i
    |=> s.running == $past(enc_lvl) && s.sp == $past(s.sp) + 5'h01)
    else $error("acknowledge did not push level");
  ack_clear_a: assert property (ack_ev && !rise[enc_src]
    |=> !s.pend[$past(enc_src)]) else $error("pending not cleared");
  exit_pop_a: assert property (exit_ev && !ack_ev && s.sp != '0
    && standby_controller_enable_i |=> s.running == $past(s.stack[s.sp[3:0] - 4'h1]))
    else $error("exit did not restore level");
  te_off_a: assert property (!s.te |-> !ack_ev && !exit_ev
    && mem_addr_o == mem_addr_i) else $error("table logic active");
  standby_rst_a: assert property (!standby_controller_enable_i
    |=> !s.req && !s.ge && !s.te && s.sp == '0) else $error("standby reset");
  pend_capture_a: assert property (rise != '0 |=> (s.pend & $past(rise)) == $past(rise))
    else $error("activation lost");
  enc_default_a: assert property (!comp |-> enc_src == '0)
    else $error("encoder not at default");
  req_gate_a: assert property ($rose(s.req) |-> $past(s.ge && s.te && comp))
    else $error("request without enables");
  m_read_a: assert property (s.wb_ack |-> !s.rdata[`VPI_NODE_M])
    else $error("modify bit read as one");
  vtb_low_a: assert property (mem_addr_o[1:0] == 2'b00 || !tbl_rd)
    else $error("vector fetch misaligned");

  cov_ack_c: cover property (ack_ev);
  cov_exit_c: cover property (exit_ev && s.sp != '0);
  cov_nest_c: cover property (s.sp == 5'h02);
  cov_default_c: cover property (tbl_rd && !comp);
endmodule : vpi_controller
`default_nettype wire

// file: verif/vpi_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "vpi_cfg.svh"
// Processor side: word loads and stores on the snooped memory bus
module vpi_cpu_model (
  input wire logic clk_i, // System clock
  input wire logic [`VPI_MEM_AW-1:0] remap_i, // Address forwarded to memory
  output logic stb_o, // Access pulse
  output logic we_o, // Store
  output logic word_o, // 32-bit access
  output logic [`VPI_MEM_AW-1:0] addr_o // Byte address
);
  // Idle address is inverted so nothing decodes by chance
  initial begin
    stb_o = 1'b0;
    we_o = 1'b0;
    word_o = 1'b0;
    addr_o = 24'hffffff;
  end
  // One routine address per table word
  function automatic logic [31:0] word_at(input logic [23:0] a);
    return {8'h00, a ^ 24'h5a0000};
  endfunction : word_at
  // One access pulse; memory answers at the forwarded address
  task automatic access(input logic w, input logic [23:0] a, output logic [31:0] d);
    @(posedge clk_i);
    stb_o <= 1'b1;
    we_o <= w;
    word_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    d = word_at(remap_i);
    stb_o <= 1'b0;
    addr_o <= ~a;
  endtask : access
endmodule : vpi_cpu_model
`default_nettype wire

// file: verif/vectored_priority_irq_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "vpi_cfg.svh"
module vectored_priority_irq_controller_bench;
  localparam logic [23:0] B = 24'h123400; // Table base, 512-byte aligned
  logic clk_i = 1'b0, rst_i = 1'b1, sby = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic ack, req_n, ms, mw, mword;
  logic [3:0] sel = 4'h0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wd = 32'h00000000, rd, q;
  logic [63:0] src = 64'h0;
  logic [23:0] ma, mo;
  int errors = 0, total_checks = 0;
  always #20 clk_i = ~clk_i;
  vpi_controller dut (.clk_i(clk_i), .rst_i(rst_i), .standby_controller_enable_i(sby),
    .source_i(src), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .mem_stb_i(ms),
    .mem_we_i(mw), .mem_word_i(mword), .mem_addr_i(ma), .mem_addr_o(mo),
    .cpu_request_n_o(req_n));
  vpi_cpu_model cpu (.clk_i(clk_i), .remap_i(mo), .stb_o(ms), .we_o(mw), .word_o(mword),
    .addr_o(ma));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Classic cycle, held until ack is seen at a rising edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= 4'hf;
    while (ack !== 1'b1) @(posedge clk_i);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string n, input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask : rdc
  task automatic pulse(input int n);
    @(posedge clk_i);
    src[n] <= 1'b1;
    @(posedge clk_i);
    src[n] <= 1'b0;
  endtask : pulse
  // Request settles two cycles after its cause
  task automatic rq(input logic e);
    repeat (3) @(posedge clk_i);
    chk("request_n", {31'h0, e}, {31'h0, req_n});
  endtask : rq
  task automatic vec(input logic [23:0] a, input int n);
    logic [31:0] d;
    cpu.access(1'b0, a, d);
    chk("vector", {8'h00, (a + 24'(4 * n)) ^ 24'h5a0000}, d);
  endtask : vec
  task automatic leave();
    logic [31:0] d;
    cpu.access(1'b1, B + 24'h000100, d);
  endtask : leave
  task automatic t_regs();
    rdc("vtb", 10'h010, 32'h0);
    wr(10'h010, 32'hffffffff);
    rdc("vtb", 10'h010, 32'h00fffe00);
    rdc("unmapped", 10'h3f0, 32'h0);
    wr(10'h010, {8'h00, B});
  endtask : t_regs
  task automatic t_node();
    wr(10'h000, 32'hc0);
    wr(10'h124, 32'hc3);
    rdc("node9", 10'h124, 32'h43);
    rq(1'b1);
    rdc("winner", 10'h00c, 32'h0);
    wr(10'h124, 32'h20);
    rdc("node9", 10'h124, 32'h60);
    rq(1'b1);
    wr(10'h124, 32'h80);
    rdc("node9", 10'h124, 32'h0);
  endtask : t_node
  task automatic t_nest();
    wr(10'h114, 32'h23);
    pulse(5);
    rq(1'b0);
    rdc("enc_level", 10'h008, 32'h3);
    rdc("enc_src", 10'h00c, 32'h5);
    vec(B, 5);
    rq(1'b1);
    rdc("node5", 10'h114, 32'h23);
    wr(10'h004, 32'h5);
    rdc("levels", 10'h004, 32'h35);
    wr(10'h11c, 32'h24);
    pulse(7);
    rq(1'b1);
    wr(10'h120, 32'h26);
    pulse(8);
    rq(1'b0);
    wr(10'h000, 32'h40);
    rq(1'b0);
    vec(B, 8);
    rdc("levels", 10'h004, 32'h65);
    leave();
    rdc("levels", 10'h004, 32'h35);
    wr(10'h004, 32'h0);
    leave();
    rdc("levels", 10'h004, 32'h0);
    rq(1'b1);
    wr(10'h000, 32'hc0);
    rq(1'b0);
    wr(10'h000, 32'h80);
    vec(B, 0);
    rq(1'b0);
    wr(10'h000, 32'hc0);
    vec(B, 7);
  endtask : t_nest
  task automatic t_sby();
    leave(); // Close node 7 routine so its level no longer blocks
    pulse(7);
    rq(1'b0);
    @(posedge clk_i);
    sby <= 1'b0;
    rq(1'b1);
    wr(10'h000, 32'hc0);
    rdc("control", 10'h000, 32'h0);
    pulse(4);
    rdc("node4", 10'h110, 32'h40);
    @(posedge clk_i);
    sby <= 1'b1;
    wr(10'h110, 32'h21);
    rq(1'b1);
    wr(10'h000, 32'hc0);
    rq(1'b0);
  endtask : t_sby
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // Main sequence, reset held for twenty cycles
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    sby <= 1'b1;
    t_regs();
    t_node();
    t_nest();
    t_sby();
    conclude();
  end
  // Watchdog, well beyond the roughly 190 cycles needed
  initial begin
    repeat (4000) @(posedge clk_i);
    errors++;
    conclude();
  end
endmodule : vectored_priority_irq_controller_bench
`default_nettype wire
